// ===== pcc_pkg.sv
// Constants, types and field layout for the PLL configuration control block
// ****************************************************************************
// ****************************************************************************
package pcc_pkg;
	// ************************************************************************
	// Register indices; byte address is four times the index
	// ************************************************************************
	localparam int          IDX_PLL_CTRL  = 'h010;      // Power, polarity, pump mode
	localparam int          IDX_ABL       = 'h017;      // Antibacklash and pump current
	localparam int          IDX_CAL       = 'h018;      // VCO calibration request
	localparam int          IDX_SRC       = 'h1E1;      // Distribution source select
	localparam int          IDX_UPDATE    = 'h232;      // Settings update strobe
	localparam int          IDX_STATUS    = 'h233;      // Block status, read only
	localparam int          ADDR_W        = 12;         // APB address width
	localparam logic [11:0] ADDR_PLL_CTRL = 12'(IDX_PLL_CTRL * 4);
	localparam logic [11:0] ADDR_ABL      = 12'(IDX_ABL * 4);
	localparam logic [11:0] ADDR_CAL      = 12'(IDX_CAL * 4);
	localparam logic [11:0] ADDR_SRC      = 12'(IDX_SRC * 4);
	localparam logic [11:0] ADDR_UPDATE   = 12'(IDX_UPDATE * 4);
	localparam logic [11:0] ADDR_STATUS   = 12'(IDX_STATUS * 4);
	// ************************************************************************
	// Field positions
	// ************************************************************************
	localparam int PWR_LSB     = 0;                      // Power field [1:0]
	localparam int POL_BIT     = 7;                      // Detector polarity
	localparam int CPM_LSB     = 4;                      // Pump mode [6:4]
	localparam int ABL_LSB     = 0;                      // Antibacklash [1:0]
	localparam int CUR_LSB     = 2;                      // Pump current [4:2]
	localparam int CAL_BIT     = 0;                      // Calibration request
	localparam int BYP_BIT     = 0;                      // VCO divider bypass
	localparam int VCO_BIT     = 1;                      // Internal VCO select
	localparam int UPDATE_BIT  = 0;                      // Update strobe bit
	// ************************************************************************
	// Reset values: PLL off, divider used, external clock selected
	// ************************************************************************
	localparam logic [7:0] RST_PLL_CTRL = 8'h01;
	localparam logic [7:0] RST_ABL      = 8'h00;
	localparam logic [7:0] RST_CAL      = 8'h00;
	localparam logic [7:0] RST_SRC      = 8'h00;
	// ************************************************************************
	// Encodings
	// ************************************************************************
	localparam logic [1:0] PWR_NORMAL   = 2'h0;          // PLL on
	localparam logic [1:0] PWR_ASYNC_PD = 2'h1;          // PLL off
	localparam logic [2:0] CPM_NORMAL   = 3'h0;          // Locking operation
	localparam logic [2:0] CPM_UP       = 3'h1;          // Test: forced up
	localparam logic [2:0] CPM_DOWN     = 3'h2;          // Test: forced down
	localparam logic [2:0] CPM_HIGHZ    = 3'h3;          // Holdover
	localparam int         PUMP_LSB_UA  = 600;           // Nominal current step
	localparam int         CAL_CYCLES_DEF = 1024;        // Calibration run length
	// Antibacklash code
	typedef logic [1:0] pccAbl_t;
	// Calibration sequencer, Gray along the usual path
	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'h0,
		CAL_RUN  = 2'h1,
		CAL_DONE = 2'h3
	} pccCal_e;
	// Settings that steer the loop and the routing
	typedef struct packed
	{
		logic [1:0] pllPower;                            // Power state
		logic       pdNegative;                          // Polarity
		logic [2:0] pumpMode;                            // Pump mode
		pccAbl_t    antibacklash;                        // Overlap width
		logic [2:0] pumpCurrent;                         // Current step
		logic       calRequest;                          // Calibration bit
		logic       divBypass;                           // Skip VCO divider
		logic       srcInternalVco;                      // Internal VCO source
	} pccCfg_s;
endpackage

// ===== pcc_phase_detector.sv
// Phase frequency detector with programmable antibacklash overlap
`timescale 1ns/100ps
module pcc_phase_detector
(
	input  wire logic           clk,        // System clock
	input  wire logic           rst_n,      // Async reset, active low
	input  wire logic           enable,     // PLL running
	input  wire logic           refRise,    // Reference divider edge pulse
	input  wire logic           fbRise,     // Feedback divider edge pulse
	input  wire pcc_pkg::pccAbl_t abWidth,  // Overlap width code
	output logic                up,         // Pump up request
	output logic                down        // Pump down request
);
	import pcc_pkg::*;

	logic    upQ;                           // Up latch
	logic    downQ;                         // Down latch
	pccAbl_t abCnt_q;                       // Overlap cycle counter
	logic    bothOn;                        // Both requests active
	logic    clearNow;                      // Overlap finished

	assign bothOn   = upQ & downQ;
	assign clearNow = bothOn && (abCnt_q == abWidth);
	assign up       = upQ;
	assign down     = downQ;

	// ************************************************************************
	// Edge latches; a new edge wins over the clear
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			upQ   <= 1'b0;
			downQ <= 1'b0;
		end
		else if (!enable)
		begin
			upQ   <= 1'b0;
			downQ <= 1'b0;
		end
		else
		begin
			upQ   <= refRise | (upQ & ~clearNow);
			downQ <= fbRise | (downQ & ~clearNow);
		end
	end

	// ************************************************************************
	// Overlap counter: both stay on for abWidth+1 cycles
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			abCnt_q <= '0;
		else if (!bothOn || clearNow)
			abCnt_q <= '0;
		else
			abCnt_q <= abCnt_q + 2'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_ab_width;
		enable && clearNow && !refRise && !fbRise ##1 enable |-> !(upQ && downQ);
	endproperty
	a_ab_width: assert property (p_ab_width) else $error("overlap too long");
endmodule

// ===== pcc_pll_config_control.sv
// PLL configuration control: APB registers, staging, update, pump and calibration
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module pcc_pll_config_control
#(
	parameter int CAL_CYCLES = pcc_pkg::CAL_CYCLES_DEF   // Calibration length
)
(
	input  wire logic          clk,            // 50 MHz system clock
	input  wire logic          rst_n,          // Async reset, active low
	input  wire logic          psel,           // APB select
	input  wire logic          penable,        // APB enable
	input  wire logic          pwrite,         // APB write
	input  wire logic [11:0]   paddr,          // APB byte address
	input  wire logic [31:0]   pwdata,         // APB write data
	output logic [31:0]        prdata,         // APB read data
	output logic               pready,         // APB ready
	output logic               pslverr,        // APB error, unmapped address
	input  wire logic          refPresentPin,  // Reference input has signal
	input  wire logic          vcoDivRunPin,   // VCO divider toggling
	input  wire logic          refDivPin,      // Reference divider output
	input  wire logic          fbDivPin,       // Feedback divider output
	output pcc_pkg::pccCfg_s   activeCfg,      // Settings in force
	output logic               pllEnabled,     // PLL powered
	output logic               pumpUp,         // Pump sourcing
	output logic               pumpDown,       // Pump sinking
	output logic               pumpHighZ,      // Pump tri-stated
	output logic               calBusy,        // Calibration running
	output logic               calDone         // Calibration finished
);
	import pcc_pkg::*;

	// ************************************************************************
	// Elaboration check
	// ************************************************************************
	if (CAL_CYCLES < 1 || CAL_CYCLES > 65535)
	begin : g_chk
		$error("CAL_CYCLES out of range");
	end

	// ************************************************************************
	// Declarations
	// ************************************************************************
	logic [7:0]  stPll_q;                      // Staged power/polarity/pump
	logic [7:0]  stAbl_q;                      // Staged antibacklash/current
	logic [7:0]  stCal_q;                      // Staged calibration
	logic [7:0]  stSrc_q;                      // Staged source select
	pccCfg_s     stagedCfg;                    // Staged settings view
	pccCfg_s     active_q;                     // Settings in force
	logic        pllEn_q;                      // PLL on flag
	logic [31:0] prdata_q;                     // Read data register
	logic        pready_q;                     // Ready register
	logic        pslverr_q;                    // Error register
	logic        setupPh;                      // APB setup phase
	logic        wrEn;                         // Write accepted this edge
	logic        updateWr;                     // Update strobe accepted
	logic [3:0]  syncA_q;                      // Pin sync stage one
	logic [3:0]  syncB_q;                      // Pin sync stage two
	logic [3:0]  syncC_q;                      // Pin sync stage three
	logic [3:0]  pinStable_q;                  // Agreed pin levels
	logic [3:0]  pinStable_d;                  // Next agreed levels
	logic        refPresent;                   // Reference present
	logic        vcoDivRun;                    // Divider running
	logic        refPrev_q;                    // Reference divider last level
	logic        fbPrev_q;                     // Feedback divider last level
	logic        refRise;                      // Reference edge
	logic        fbRise;                       // Feedback edge
	logic        pfdUp;                        // Detector up
	logic        pfdDown;                      // Detector down
	logic        swapPol;                      // Inverted tuning slope
	logic        pumpUp_q;                     // Pump up register
	logic        pumpDown_q;                   // Pump down register
	logic        pumpHighZ_q;                  // Pump high-Z register
	pccCal_e     calSt_q;                      // Calibration state
	logic [15:0] calCnt_q;                     // Calibration counter
	logic        calStart;                     // Calibration begins
	logic        calStop;                      // Calibration reset

	// ************************************************************************
	// Helper functions
	// ************************************************************************
	// Address decode for any mapped register
	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == ADDR_PLL_CTRL) || (a == ADDR_ABL) || (a == ADDR_CAL) ||
			(a == ADDR_SRC) || (a == ADDR_UPDATE) || (a == ADDR_STATUS);
	endfunction

	// Assemble settings from the four staged bytes
	function automatic pccCfg_s packCfg(input logic [7:0] p, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] s);
		pccCfg_s r;
		r.pllPower       = p[PWR_LSB +: 2];
		r.pdNegative     = p[POL_BIT];
		r.pumpMode       = p[CPM_LSB +: 3];
		r.antibacklash   = b[ABL_LSB +: 2];
		r.pumpCurrent    = b[CUR_LSB +: 3];
		r.calRequest     = c[CAL_BIT];
		r.divBypass      = s[BYP_BIT];
		r.srcInternalVco = s[VCO_BIT];
		packCfg = r;
	endfunction

	assign setupPh   = psel & ~penable;
	assign wrEn      = psel & penable & pready_q & pwrite;
	assign updateWr  = wrEn && (paddr == ADDR_UPDATE) && pwdata[UPDATE_BIT];
	assign stagedCfg = packCfg(stPll_q, stAbl_q, stCal_q, stSrc_q);

	// ************************************************************************
	// APB answer: ready in the access phase, data and error set up ahead
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= setupPh;
			pslverr_q <= setupPh & ~isMapped(paddr);
		end
	end

	// Read mux, captured during setup
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata_q <= '0;
		else if (setupPh && !pwrite)
		begin
			case (paddr)
				ADDR_PLL_CTRL: prdata_q <= {24'h000000, stPll_q};
				ADDR_ABL:      prdata_q <= {24'h000000, stAbl_q};
				ADDR_CAL:      prdata_q <= {24'h000000, stCal_q};
				ADDR_SRC:      prdata_q <= {24'h000000, stSrc_q};
				// Block state
				ADDR_STATUS:   prdata_q <= {26'h0, vcoDivRun, refPresent,
					pllEn_q, calDone, calBusy, active_q.srcInternalVco};
				// Update strobe and unmapped read as zero
				default:       prdata_q <= '0;
			endcase
		end
	end

	// ************************************************************************
	// Staging registers; software writes never reach the loop directly
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stPll_q <= RST_PLL_CTRL;
			stAbl_q <= RST_ABL;
			stCal_q <= RST_CAL;
			stSrc_q <= RST_SRC;
		end
		else if (wrEn)
		begin
			case (paddr)
				ADDR_PLL_CTRL: stPll_q <= pwdata[7:0];
				ADDR_ABL:      stAbl_q <= pwdata[7:0];
				ADDR_CAL:      stCal_q <= pwdata[7:0];
				ADDR_SRC:      stSrc_q <= pwdata[7:0];
				// Others hold
				default:       stPll_q <= stPll_q;
			endcase
		end
	end

	// ************************************************************************
	// Active copy: loaded only by the update strobe
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_q <= packCfg(RST_PLL_CTRL, RST_ABL, RST_CAL, RST_SRC);
			pllEn_q  <= 1'b0;
		end
		else if (updateWr)
		begin
			active_q <= stagedCfg;
			pllEn_q  <= (stagedCfg.pllPower == PWR_NORMAL);
		end
	end

	// ************************************************************************
	// Pin synchronisers: a change counts once stages two and three agree
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA_q     <= '0;
			syncB_q     <= '0;
			syncC_q     <= '0;
			pinStable_q <= '0;
		end
		else
		begin
			syncA_q     <= {fbDivPin, refDivPin, vcoDivRunPin, refPresentPin};
			syncB_q     <= syncA_q;
			syncC_q     <= syncB_q;
			pinStable_q <= pinStable_d;
		end
	end

	assign pinStable_d = (~(syncB_q ^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & pinStable_q);
	assign refPresent  = pinStable_q[0];
	assign vcoDivRun   = pinStable_q[1];

	// Divider edge detection on the agreed levels
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			refPrev_q <= 1'b0;
			fbPrev_q  <= 1'b0;
		end
		else
		begin
			refPrev_q <= pinStable_q[2];
			fbPrev_q  <= pinStable_q[3];
		end
	end

	assign refRise = pinStable_q[2] & ~refPrev_q;
	assign fbRise  = pinStable_q[3] & ~fbPrev_q;

	// ************************************************************************
	// Phase frequency detector
	// ************************************************************************
	pcc_phase_detector u_pfd
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.enable  (pllEn_q),
		.refRise (refRise),
		.fbRise  (fbRise),
		.abWidth (active_q.antibacklash),
		.up      (pfdUp),
		.down    (pfdDown)
	);

	// Polarity only matters for an external oscillator
	assign swapPol = active_q.pdNegative & ~active_q.srcInternalVco;

	// ************************************************************************
	// Charge pump drive
	// ************************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pumpUp_q    <= 1'b0;
			pumpDown_q  <= 1'b0;
			pumpHighZ_q <= 1'b1;
		end
		else if (!pllEn_q)
		begin
			// PLL off: loop open
			pumpUp_q    <= 1'b0;
			pumpDown_q  <= 1'b0;
			pumpHighZ_q <= 1'b1;
		end
		else
		begin
			case (active_q.pumpMode)
				CPM_NORMAL:
				begin
					pumpUp_q    <= swapPol ? pfdDown : pfdUp;
					pumpDown_q  <= swapPol ? pfdUp : pfdDown;
					pumpHighZ_q <= 1'b0;
				end
				CPM_UP:
				begin
					pumpUp_q    <= 1'b1;
					pumpDown_q  <= 1'b0;
					pumpHighZ_q <= 1'b0;
				end
				CPM_DOWN:
				begin
					pumpUp_q    <= 1'b0;
					pumpDown_q  <= 1'b1;
					pumpHighZ_q <= 1'b0;
				end
				// High-Z holdover and unused codes
				default:
				begin
					pumpUp_q    <= 1'b0;
					pumpDown_q  <= 1'b0;
					pumpHighZ_q <= 1'b1;
				end
			endcase
		end
	end

	// ************************************************************************
	// VCO calibration: starts on update that raises the request bit
	// ************************************************************************
	assign calStart = updateWr && stagedCfg.calRequest && !active_q.calRequest;
	assign calStop  = updateWr && !stagedCfg.calRequest;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			calSt_q  <= CAL_IDLE;
			calCnt_q <= '0;
		end
		else if (calStop)
		begin
			// Clearing the bit resets calibration
			calSt_q  <= CAL_IDLE;
			calCnt_q <= '0;
		end
		else
		begin
			case (calSt_q)
				CAL_IDLE:
				begin
					if (calStart)
						calSt_q <= CAL_RUN;
					calCnt_q <= '0;
				end
				CAL_RUN:
				begin
					// Progress only with reference present and divider running
					if (refPresent && vcoDivRun)
					begin
						if (calCnt_q == 16'(CAL_CYCLES - 1))
							calSt_q <= CAL_DONE;
						calCnt_q <= calCnt_q + 16'h0001;
					end
				end
				CAL_DONE:
					calSt_q <= CAL_DONE;
				default:
					calSt_q <= CAL_IDLE;
			endcase
		end
	end

	// ************************************************************************
	// Outputs
	// ************************************************************************
	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign activeCfg  = active_q;
	assign pllEnabled = pllEn_q;
	assign pumpUp     = pumpUp_q;
	assign pumpDown   = pumpDown_q;
	assign pumpHighZ  = pumpHighZ_q;
	assign calBusy    = (calSt_q == CAL_RUN);
	assign calDone    = (calSt_q == CAL_DONE);

	// ************************************************************************
	// Assertions
	// ************************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pwr_down;
		active_q.pllPower != PWR_NORMAL |-> !pllEn_q ##1 (!pllEn_q || $past(updateWr));
	endproperty
	a_pwr_down: assert property (p_pwr_down) else $error("PLL on while powered down");

	property p_pwr_on;
		active_q.pllPower == PWR_NORMAL |-> pllEn_q;
	endproperty
	a_pwr_on: assert property (p_pwr_on) else $error("PLL off in normal power");

	property p_hold;
		!updateWr |=> $stable(active_q);
	endproperty
	a_hold: assert property (p_hold) else $error("active settings moved without update");

	property p_apply;
		updateWr |=> active_q == $past(stagedCfg);
	endproperty
	a_apply: assert property (p_apply) else $error("update did not apply staged values");

	property p_forced_up;
		pllEn_q && active_q.pumpMode == CPM_UP ##1 pllEn_q && active_q.pumpMode == CPM_UP
			|-> pumpUp_q && !pumpDown_q && !pumpHighZ_q;
	endproperty
	a_forced_up: assert property (p_forced_up) else $error("forced up not driven");

	property p_off_highz;
		!pllEn_q |=> pumpHighZ_q && !pumpUp_q && !pumpDown_q;
	endproperty
	a_off_highz: assert property (p_off_highz) else $error("pump active with PLL off");

	property p_int_pol;
		pllEn_q && active_q.srcInternalVco && active_q.pumpMode == CPM_NORMAL && pfdUp && !pfdDown
			|=> pumpUp_q && !pumpDown_q;
	endproperty
	a_int_pol: assert property (p_int_pol) else $error("polarity used with internal VCO");

	property p_ext_neg;
		pllEn_q && !active_q.srcInternalVco && active_q.pdNegative &&
			active_q.pumpMode == CPM_NORMAL && pfdUp && !pfdDown |=> pumpDown_q && !pumpUp_q;
	endproperty
	a_ext_neg: assert property (p_ext_neg) else $error("negative polarity not applied");

	property p_cal_start;
		calStart |=> calBusy;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

	property p_cal_hold;
		calBusy && !(refPresent && vcoDivRun) && !updateWr |=> $stable(calCnt_q);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibration advanced without reference");
endmodule

// ===== pll_config_control_tb_top.sv
// Self-checking bench for the PLL configuration control block
`timescale 1ns/100ps
module pll_config_control_tb_top;
	import pcc_pkg::*;
	logic        clk = 1'b0;        // 50 MHz clock
	logic        rst_n = 1'b0;      // Reset, active low
	logic        psel = 1'b0;       // APB select
	logic        penable = 1'b0;    // APB enable
	logic        pwrite = 1'b0;     // APB direction
	logic [11:0] paddr = 12'h000;   // APB address
	logic [31:0] pwdata = 32'h0;    // APB write data
	logic        refDivPin = 1'b0;  // Reference divider edge source
	logic        fbDivPin = 1'b0;   // Feedback divider edge source
	logic        refPresentPin = 1'b1; // Reference signal present
	logic [31:0] prdata;            // Read data
	logic        pready;            // Ready
	logic        pslverr;           // Error
	pccCfg_s     cfg;               // Settings in force
	logic        pllEn;             // PLL powered
	logic        up;                // Pump up
	logic        dn;                // Pump down
	logic        hz;                // Pump high-Z
	logic        busy;              // Calibrating
	logic        done;              // Calibrated
	logic [31:0] rd;                // Last read data
	logic        er;                // Last error flag
	int          n_errors = 0;      // Mismatches
	int          checks = 0;        // Comparisons
	pcc_pll_config_control #(.CAL_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.refPresentPin(refPresentPin), .vcoDivRunPin(1'b1), .refDivPin(refDivPin), .fbDivPin(fbDivPin),
		.activeCfg(cfg), .pllEnabled(pllEn), .pumpUp(up), .pumpDown(dn), .pumpHighZ(hz),
		.calBusy(busy), .calDone(done));
	// ********************************************************************
	// Tasks
	// ********************************************************************
	// One APB transfer; holds the request until pready, then releases it
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Update strobe, then let outputs settle for the pump stage
	task upd();
		xf(1'b1, ADDR_UPDATE, 32'h1);
		repeat (2) @(posedge clk);
	endtask
	// Compare one value
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts and verdict
	task close_out();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ********************************************************************
	// Clock, watchdog and tests
	// ********************************************************************
	initial forever #10 clk = ~clk;
	initial
	begin
		#400000;
		n_errors++;
		close_out();
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		xf(1'b0, ADDR_PLL_CTRL, 32'h0);
		chk("pll_ctrl reset", rd, 32'h01);
		chk("power off", {pllEn, hz}, 2'b01);
		// Staged writes, forced up mode, bypass, external source
		xf(1'b1, ADDR_PLL_CTRL, 32'h10);
		xf(1'b1, ADDR_SRC, 32'h01);
		xf(1'b1, ADDR_ABL, 32'h1F);
		xf(1'b1, ADDR_UPDATE, 32'h0);
		chk("staged only", cfg.pllPower, 2'h1);
		upd();
		chk("power on", pllEn, 1'b1);
		chk("bypass", {cfg.divBypass, cfg.srcInternalVco}, 2'b10);
		chk("abl cur", {cfg.antibacklash, cfg.pumpCurrent}, 5'h1F);
		$display("test config done");
		// Every pump mode, no divider edges present
		for (int m = 0; m < 4; m++)
		begin
			xf(1'b1, ADDR_PLL_CTRL, 32'(m << 4));
			upd();
			chk("pump", {up, dn, hz}, (m == 1) ? 3'b100 : (m == 2) ? 3'b010 : (m == 3) ? 3'b001 : 3'b000);
		end
		$display("test pump modes done");
		// Negative polarity with external source swaps the detector output
		xf(1'b1, ADDR_PLL_CTRL, 32'h80);
		upd();
		refDivPin <= 1'b1;
		repeat (8) @(posedge clk);
		chk("neg pol", {up, dn}, 2'b01);
		xf(1'b1, ADDR_SRC, 32'h02);
		upd();
		chk("int vco", {cfg.srcInternalVco, up, dn}, 3'b110);
		// Feedback edge: both requests overlap for antibacklash+1 cycles, then clear
		fbDivPin <= 1'b1;
		repeat (10) @(posedge clk);
		chk("overlap on", {up, dn}, 2'b11);
		@(posedge clk);
		chk("overlap off", {up, dn}, 2'b00);
		$display("test polarity done");
		xf(1'b0, 12'h004, 32'h0);
		chk("unmapped err", er, 1'b1);
		chk("unmapped data", rd, 32'h0);
		// Calibration stalls while the reference is missing
		refPresentPin <= 1'b0;
		xf(1'b1, ADDR_CAL, 32'h1);
		upd();
		chk("cal busy", busy, 1'b1);
		repeat (8) @(posedge clk);
		chk("cal stalled", {busy, done}, 2'b10);
		refPresentPin <= 1'b1;
		repeat (12) @(posedge clk);
		chk("cal done", {busy, done}, 2'b01);
		xf(1'b0, ADDR_STATUS, 32'h0);
		chk("status", rd, 32'h3D);
		$display("test calibration done");
		// Reset in mid-run returns outputs and registers to their defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset cfg", cfg, {PWR_ASYNC_PD, 12'h000});
		chk("reset outs", {pllEn, hz, busy, done, pready, pslverr}, 6'b010000);
		rst_n <= 1'b1;
		xf(1'b0, ADDR_PLL_CTRL, 32'h0);
		chk("pll_ctrl after reset", rd, {24'h000000, RST_PLL_CTRL});
		$display("test reset done");
		close_out();
	end
endmodule
